// [logic/fbpp_pkg.sv]
package fbpp_pkg;

	// ****************************************
	// Clock and timing
	// ****************************************
	localparam int unsigned CLK_MHZ = 200;
	// Nominal times in ns, picked inside their tolerance windows
	localparam int unsigned SETUP_NS = 500;
	localparam int unsigned STROBE_NS = 5500;
	localparam int unsigned SAMPLE_NS = 12000;
	localparam int unsigned RXSTB_NS = 1000;
	localparam int unsigned RXCLK_NS = 500;
	localparam int unsigned SETUP_CYC = (SETUP_NS * CLK_MHZ + 999) / 1000;
	localparam int unsigned STROBE_CYC = (STROBE_NS * CLK_MHZ + 999) / 1000;
	localparam int unsigned SAMPLE_CYC = (SAMPLE_NS * CLK_MHZ + 999) / 1000;
	localparam int unsigned RXSTB_CYC = (RXSTB_NS * CLK_MHZ + 999) / 1000;
	localparam int unsigned RXCLK_CYC = (RXCLK_NS * CLK_MHZ + 999) / 1000;
	localparam int unsigned CNT_W = 12;

	// ****************************************
	// Register map
	// ****************************************
	localparam int unsigned ADR_W = 8;
	localparam logic [7:0] CTRL_OFS = 8'h00;
	localparam logic [7:0] PARAM_OFS = 8'h04;
	localparam logic [7:0] CMD_OFS = 8'h08;
	localparam logic [7:0] STATUS_OFS = 8'h0C;
	localparam int unsigned CTRL_W = 7;
	localparam int unsigned CTRL_MODE_LSB = 0;
	localparam int unsigned CTRL_BIDIR_BIT = 2;
	localparam int unsigned CTRL_WDOG_FORCED_BIT = 3;
	localparam int unsigned CTRL_WDOG_PIN_BIT = 4;
	localparam int unsigned CTRL_FILTER_PIN_BIT = 5;
	localparam int unsigned CTRL_SYNC_PIN_BIT = 6;
	localparam logic [6:0] CTRL_RST = 7'h00;
	localparam logic [3:0] PARAM_RST = 4'hF;
	localparam int unsigned CMD_CLEAR_BIT = 0;
	localparam int unsigned STAT_SAMPLE_LSB = 0;
	localparam int unsigned STAT_BUSY_BIT = 4;
	localparam int unsigned STAT_DPORT_BIT = 5;
	localparam int unsigned STAT_FLAG_BIT = 6;
	localparam int unsigned STAT_WDOG_BIT = 7;
	localparam int unsigned STAT_FILTER_BIT = 8;
	localparam int unsigned STAT_SYNC_BIT = 9;
	localparam int unsigned STAT_STBPIN_BIT = 10;
	localparam logic [31:0] RDATA_RST = 32'h0000_0000;

	// ****************************************
	// Types
	// ****************************************
	typedef enum logic [1:0] {
		FBPP_MODE_SLAVE = 2'h0,
		FBPP_MODE_MASTER = 2'h1,
		FBPP_MODE_REPEATER = 2'h2,
		FBPP_MODE_MONITOR = 2'h3
	} fbpp_mode_t;

	typedef enum logic [3:0] {
		FBPP_ST_IDLE = 4'h1,
		FBPP_ST_SETUP = 4'h2,
		FBPP_ST_STROBE = 4'h4,
		FBPP_ST_WAIT = 4'h8
	} fbpp_state_t;

endpackage

// [logic/fbpp_sync.sv]
`timescale 1ns/100ps
module fbpp_sync #(
	parameter int unsigned WIDTH = 4
) (
	input wire logic clk_sys,
	input wire logic rst_b,
	input wire logic [WIDTH-1:0] asyncIn,
	output logic [WIDTH-1:0] syncOut
);

	typedef struct packed {
		logic [WIDTH-1:0] stage1;
		logic [WIDTH-1:0] stage2;
	} fbpp_sync_t;

	fbpp_sync_t q;
	fbpp_sync_t d;

	// First stage feeds only the second, to let metastability settle
	always_comb begin
		d.stage1 = asyncIn;
		d.stage2 = q.stage1;
	end

	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	assign syncOut = q.stage2;

endmodule

// [logic/fbpp_pulse.sv]
`timescale 1ns/100ps
module fbpp_pulse #(
	parameter int unsigned WIDTH_CYC = 200
) (
	input wire logic clk_sys,
	input wire logic rst_b,
	input wire logic trigger,
	output logic active
);

	localparam int unsigned CW = $clog2(WIDTH_CYC + 1);

	typedef struct packed {
		logic act;
		logic [CW-1:0] cnt;
	} fbpp_pulse_t;

	fbpp_pulse_t q;
	fbpp_pulse_t d;

	// Retrigger restarts the full width, so back-to-back events merge
	always_comb begin
		d = q;
		if (trigger) begin
			d.act = 1'b1;
			d.cnt = CW'(WIDTH_CYC - 1);
		end else if (q.act) begin
			if (q.cnt == '0) begin
				d.act = 1'b0;
			end else begin
				d.cnt = q.cnt - 1'b1;
			end
		end
	end

	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	assign active = q.act;

endmodule

// [logic/fbpp_port.sv]
// Local design decisions: the address map and the Wishbone slave port.
`timescale 1ns/100ps
module fbpp_port (
	input wire logic clk_sys,
	input wire logic rst_b,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	input wire logic [3:0] paramPinIn,
	output logic [3:0] paramPinOut,
	output logic [3:0] paramPinOe,
	input wire logic paramStrobePinIn,
	output logic paramStrobePinOut,
	output logic paramStrobePinOe,
	input wire logic rxBitValid,
	input wire logic rxBitData,
	input wire logic powerFail,
	input wire logic slaveTelegramOk,
	input wire logic masterTelegramOk,
	output logic receiveDataOutPin,
	output logic dataPortEnable,
	output logic wdogEnable,
	output logic filterActive,
	output logic syncIoActive
);

	// ****************************************
	// State
	// ****************************************
	typedef struct packed {
		fbpp_pkg::fbpp_state_t st;
		logic [fbpp_pkg::CNT_W-1:0] cnt;
		logic [3:0] paramOut;
		logic [3:0] pend;
		logic pendValid;
		logic [3:0] drvEn;
		logic strobe;
		logic [3:0] sampled;
		logic sampleFlag;
		logic sampleStb;
		logic dataPortEn;
		logic [fbpp_pkg::CTRL_W-1:0] ctrl;
		logic ack;
		logic [31:0] rdata;
		logic [3:0] pinOe;
		logic rxData;
		logic wdogEn;
		logic filterAct;
		logic syncAct;
	} fbpp_main_t;

	// Reset starts a strobe sequence with all ones, as a clear does
	localparam fbpp_main_t RST = '{
		st: fbpp_pkg::FBPP_ST_SETUP,
		cnt: '0,
		paramOut: fbpp_pkg::PARAM_RST,
		pend: fbpp_pkg::PARAM_RST,
		pendValid: 1'b0,
		drvEn: 4'h0,
		strobe: 1'b0,
		sampled: 4'h0,
		sampleFlag: 1'b0,
		sampleStb: 1'b0,
		dataPortEn: 1'b0,
		ctrl: fbpp_pkg::CTRL_RST,
		ack: 1'b0,
		rdata: fbpp_pkg::RDATA_RST,
		pinOe: 4'h0,
		rxData: 1'b0,
		wdogEn: 1'b0,
		filterAct: 1'b0,
		syncAct: 1'b0
	};

	localparam logic [fbpp_pkg::CNT_W-1:0] SETUP_END = fbpp_pkg::CNT_W'(fbpp_pkg::SETUP_CYC - 1);
	localparam logic [fbpp_pkg::CNT_W-1:0] STROBE_END =
		fbpp_pkg::CNT_W'(fbpp_pkg::SETUP_CYC + fbpp_pkg::STROBE_CYC - 1);
	localparam logic [fbpp_pkg::CNT_W-1:0] SAMPLE_END = fbpp_pkg::CNT_W'(fbpp_pkg::SAMPLE_CYC - 1);

	fbpp_main_t q;
	fbpp_main_t d;
	logic [3:0] pinSync;
	logic stbPinSync;
	logic rxClk;
	logic slvStb;
	logic mstStb;
	logic busAcc;
	logic wrAcc;
	logic wrParam;
	logic wrClear;
	logic [3:0] liveP;
	logic isSlave;
	logic bidir;
	fbpp_pkg::fbpp_mode_t mode;

	// ****************************************
	// Pin synchronisers and one-shots
	// ****************************************
	fbpp_sync #(
		.WIDTH(5)
	) uSync (
		.clk_sys(clk_sys),
		.rst_b(rst_b),
		.asyncIn({paramStrobePinIn, paramPinIn}),
		.syncOut({stbPinSync, pinSync})
	);

	fbpp_pulse #(
		.WIDTH_CYC(fbpp_pkg::RXCLK_CYC)
	) uRxClk (
		.clk_sys(clk_sys),
		.rst_b(rst_b),
		.trigger(rxBitValid),
		.active(rxClk)
	);

	fbpp_pulse #(
		.WIDTH_CYC(fbpp_pkg::RXSTB_CYC)
	) uSlvStb (
		.clk_sys(clk_sys),
		.rst_b(rst_b),
		.trigger(slaveTelegramOk),
		.active(slvStb)
	);

	fbpp_pulse #(
		.WIDTH_CYC(fbpp_pkg::RXSTB_CYC)
	) uMstStb (
		.clk_sys(clk_sys),
		.rst_b(rst_b),
		.trigger(masterTelegramOk),
		.active(mstStb)
	);

	// ****************************************
	// Next state
	// ****************************************
	assign mode = fbpp_pkg::fbpp_mode_t'(q.ctrl[fbpp_pkg::CTRL_MODE_LSB +: 2]);
	assign isSlave = (mode == fbpp_pkg::FBPP_MODE_SLAVE);
	assign bidir = q.ctrl[fbpp_pkg::CTRL_BIDIR_BIT];
	assign busAcc = wb_cyc_i & wb_stb_i & ~q.ack;
	assign wrAcc = busAcc & wb_we_i & wb_sel_i[0];
	assign wrParam = wrAcc && (wb_adr_i == fbpp_pkg::PARAM_OFS);
	assign wrClear = wrAcc && (wb_adr_i == fbpp_pkg::CMD_OFS) && wb_dat_i[fbpp_pkg::CMD_CLEAR_BIT];
	assign liveP = pinSync & q.paramOut;

	always_comb begin
		d = q;
		d.ack = busAcc;
		d.sampleStb = 1'b0;
		// Unmapped addresses answer with zero and ignore writes
		if (busAcc) begin
			d.rdata = 32'h0000_0000;
			if (wb_adr_i == fbpp_pkg::CTRL_OFS) begin
				d.rdata[fbpp_pkg::CTRL_W-1:0] = q.ctrl;
			end else if (wb_adr_i == fbpp_pkg::PARAM_OFS) begin
				d.rdata[3:0] = q.paramOut;
			end else if (wb_adr_i == fbpp_pkg::STATUS_OFS) begin
				d.rdata[fbpp_pkg::STAT_SAMPLE_LSB +: 4] = q.sampled;
				d.rdata[fbpp_pkg::STAT_BUSY_BIT] = (q.st != fbpp_pkg::FBPP_ST_IDLE) | q.pendValid;
				d.rdata[fbpp_pkg::STAT_DPORT_BIT] = q.dataPortEn;
				d.rdata[fbpp_pkg::STAT_FLAG_BIT] = q.sampleFlag;
				d.rdata[fbpp_pkg::STAT_WDOG_BIT] = q.wdogEn;
				d.rdata[fbpp_pkg::STAT_FILTER_BIT] = q.filterAct;
				d.rdata[fbpp_pkg::STAT_SYNC_BIT] = q.syncAct;
				d.rdata[fbpp_pkg::STAT_STBPIN_BIT] = stbPinSync;
			end
		end
		if (wrAcc && (wb_adr_i == fbpp_pkg::CTRL_OFS)) begin
			d.ctrl = wb_dat_i[fbpp_pkg::CTRL_W-1:0];
		end
		// Clear comes first so a sample in the same cycle sets it again
		if (wrAcc && (wb_adr_i == fbpp_pkg::STATUS_OFS) && wb_dat_i[fbpp_pkg::STAT_FLAG_BIT]) begin
			d.sampleFlag = 1'b0;
		end
		if (q.st != fbpp_pkg::FBPP_ST_IDLE) begin
			d.cnt = q.cnt + 1'b1;
		end
		case (q.st)
			fbpp_pkg::FBPP_ST_SETUP: begin
				if (q.cnt == SETUP_END) begin
					d.st = fbpp_pkg::FBPP_ST_STROBE;
				end
			end
			fbpp_pkg::FBPP_ST_STROBE: begin
				if (q.cnt == STROBE_END) begin
					d.st = fbpp_pkg::FBPP_ST_WAIT;
				end
			end
			fbpp_pkg::FBPP_ST_WAIT: begin
				if (q.cnt == SAMPLE_END) begin
					d.st = fbpp_pkg::FBPP_ST_IDLE;
					d.sampleStb = 1'b1;
					d.sampleFlag = 1'b1;
					d.sampled = bidir ? pinSync : (pinSync & q.paramOut);
					d.drvEn = ~q.paramOut;
				end
			end
			default: begin
			end
		endcase
		// A write during a sequence waits; the latest value wins
		if (wrParam) begin
			d.pend = wb_dat_i[3:0];
			d.pendValid = 1'b1;
		end
		if (wrClear) begin
			// Clear aborts and restarts with all ones
			d.st = fbpp_pkg::FBPP_ST_SETUP;
			d.cnt = '0;
			d.paramOut = fbpp_pkg::PARAM_RST;
			d.drvEn = 4'h0;
			d.pendValid = 1'b0;
			d.dataPortEn = 1'b0;
		end else if ((d.st == fbpp_pkg::FBPP_ST_IDLE) && d.pendValid) begin
			d.st = fbpp_pkg::FBPP_ST_SETUP;
			d.cnt = '0;
			d.paramOut = d.pend;
			d.pendValid = 1'b0;
			// Bidir keeps drivers off from setup until the sample point
			d.drvEn = bidir ? 4'h0 : ~d.pend;
			d.dataPortEn = 1'b1;
		end
		d.strobe = (d.st == fbpp_pkg::FBPP_ST_STROBE);
		case (mode)
			fbpp_pkg::FBPP_MODE_SLAVE: d.pinOe = d.drvEn;
			// Power fail released high; strobes release pin
			fbpp_pkg::FBPP_MODE_MASTER: d.pinOe = {1'b0, ~slvStb, ~powerFail, ~rxClk};
			fbpp_pkg::FBPP_MODE_MONITOR: d.pinOe = {~mstStb, ~slvStb, ~powerFail, ~rxClk};
			default: d.pinOe = 4'h0;
		endcase
		if (rxBitValid) begin
			d.rxData = rxBitData;
		end
		// Pin functions only in slave mode
		d.wdogEn = q.ctrl[fbpp_pkg::CTRL_WDOG_FORCED_BIT] |
			(isSlave & q.ctrl[fbpp_pkg::CTRL_WDOG_PIN_BIT] & liveP[0]);
		d.filterAct = isSlave & q.ctrl[fbpp_pkg::CTRL_FILTER_PIN_BIT] & ~liveP[1];
		d.syncAct = isSlave & q.ctrl[fbpp_pkg::CTRL_SYNC_PIN_BIT] & ~liveP[2];
	end

	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			q <= RST;
		end else begin
			q <= d;
		end
	end

	// ****************************************
	// Outputs
	// ****************************************
	// Open-drain pins only ever pull low
	assign paramPinOut = 4'h0;
	assign paramPinOe = q.pinOe;
	// Strobe pin is released high for the pulse, held low otherwise
	assign paramStrobePinOut = 1'b0;
	assign paramStrobePinOe = ~q.strobe;
	assign receiveDataOutPin = q.rxData;
	assign dataPortEnable = q.dataPortEn;
	assign wdogEnable = q.wdogEn;
	assign filterActive = q.filterAct;
	assign syncIoActive = q.syncAct;
	assign wb_dat_o = q.rdata;
	assign wb_ack_o = q.ack;

	// ****************************************
	// Checks
	// ****************************************
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (!rst_b);

	logic [fbpp_pkg::CNT_W-1:0] strobeLen;
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			strobeLen <= '0;
		end else if (q.strobe) begin
			strobeLen <= strobeLen + 1'b1;
		end else begin
			strobeLen <= '0;
		end
	end

	// A clear may cut a running strobe short; only a strobe that ran into the wait phase is measured
	a_strobe_width: assert property (($fell(q.strobe) && q.st == fbpp_pkg::FBPP_ST_WAIT) |-> strobeLen == 12'h044C)
		else $error("strobe width not 1100 cycles");
	a_setup_lead: assert property ($rose(q.strobe) |-> q.cnt == 12'h0064)
		else $error("strobe did not follow 100 setup cycles");
	a_sample_point: assert property (q.sampleStb |-> $past(q.cnt) == 12'h095F)
		else $error("sample not at cycle 2400");
	a_bidir_hiz: assert property ((q.strobe && bidir && isSlave && $stable(q.ctrl)) |-> q.pinOe == 4'h0)
		else $error("driver on during bidir strobe");
	a_clear_value: assert property (wrClear |=> q.paramOut == 4'hF && q.drvEn == 4'h0 ##1 !q.strobe[*8])
		else $error("clear did not restart with all ones");
	a_sample_and: assert property ((q.sampleStb && !$past(bidir)) |-> (q.sampled & ~$past(q.paramOut)) == 4'h0)
		else $error("wired-AND sample has bits set");
	a_dport_cause: assert property ($rose(q.dataPortEn) |-> $past(wrParam, 1) || $past(q.pendValid))
		else $error("data port enabled without parameter event");
	a_repeater_hiz: assert property ($past(mode) == fbpp_pkg::FBPP_MODE_REPEATER |-> q.pinOe == 4'h0)
		else $error("repeater mode drives a pin");
	a_rx_strobe: assert property ((mode == fbpp_pkg::FBPP_MODE_MASTER && $stable(q.ctrl) && slaveTelegramOk)
		|=> ##1 !q.pinOe[2] [*8])
		else $error("slave strobe did not release pin");
	a_wdog_gate: assert property ((isSlave && $stable(q.ctrl) && !q.ctrl[fbpp_pkg::CTRL_WDOG_FORCED_BIT]
		&& !q.ctrl[fbpp_pkg::CTRL_WDOG_PIN_BIT]) |=> !q.wdogEn)
		else $error("watchdog enabled without control");

	c_param_seq: cover property ($rose(q.dataPortEn) ##[90:110] $rose(q.strobe));
	c_clear_seq: cover property (wrClear ##[90:110] $rose(q.strobe));
	c_bidir_sample: cover property (bidir && q.sampleStb);
	c_master_strobe: cover property (mode == fbpp_pkg::FBPP_MODE_MONITOR && mstStb);

endmodule

// [verification/fbpp_partner.sv]
`timescale 1ns/100ps
// ****************************************
// Far-side logic on the parameter pins
// ****************************************
module fbpp_partner (
	input wire logic clk_sys,
	input wire logic rst_b,
	input wire logic strobeLevel,
	input wire logic bidirMode,
	input wire logic [3:0] returnVal,
	output logic [3:0] extLow
);
	logic inStrobe_q;

	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			inStrobe_q <= 1'b0;
		end else begin
			inStrobe_q <= strobeLevel;
		end
	end

	// release during strobe, return data after it, hold it
	// legacy use keeps the return value driven all the time
	assign extLow = (bidirMode && inStrobe_q) ? 4'h0 : ~returnVal;
endmodule

// [verification/fbpp_port_tb_top.sv]
`timescale 1ns/100ps
module fbpp_port_tb_top;
	logic clk_sys, rst_b, wbCyc, wbStb, wbWe, wbAck, strobeOe, strobeOut, strobeLevel;
	logic [7:0] wbAdr;
	logic [3:0] wbSel, pinOe, pinOut, pinLevel, returnVal, extLow;
	logic [31:0] wbDatW, wbDatR, r;
	logic rxBitValid, rxBitData, powerFail, slaveTelegramOk, masterTelegramOk;
	logic rxOut, dpEn, wdogEn, filtAct, syncAct, bidirMode;
	logic [4:0] probe;
	int failCount, samplesChecked, cycleCnt, gap, width;
	logic [3:0] ctlExt [3] = '{4'h2, 4'hD, 4'hD};
	logic [3:0] ctlPar [3] = '{4'hF, 4'hF, 4'hE};
	logic [2:0] ctlExp [3] = '{3'b001, 3'b110, 3'b010};

	// Pull-ups on every pin, so a released line reads high
	assign pinLevel = (~pinOe | pinOut) & ~extLow;
	assign strobeLevel = strobeOe ? strobeOut : 1'b1;
	assign probe = {strobeOe, pinOe};

	fbpp_port u_dut (.clk_sys(clk_sys), .rst_b(rst_b), .wb_cyc_i(wbCyc), .wb_stb_i(wbStb), .wb_we_i(wbWe),
		.wb_adr_i(wbAdr), .wb_sel_i(wbSel), .wb_dat_i(wbDatW), .wb_dat_o(wbDatR), .wb_ack_o(wbAck),
		.paramPinIn(pinLevel), .paramPinOut(pinOut), .paramPinOe(pinOe), .paramStrobePinIn(strobeLevel),
		.paramStrobePinOut(strobeOut), .paramStrobePinOe(strobeOe), .rxBitValid(rxBitValid),
		.rxBitData(rxBitData), .powerFail(powerFail), .slaveTelegramOk(slaveTelegramOk),
		.masterTelegramOk(masterTelegramOk), .receiveDataOutPin(rxOut), .dataPortEnable(dpEn),
		.wdogEnable(wdogEn), .filterActive(filtAct), .syncIoActive(syncAct));

	fbpp_partner u_partner (.clk_sys(clk_sys), .rst_b(rst_b), .strobeLevel(strobeLevel),
		.bidirMode(bidirMode), .returnVal(returnVal), .extLow(extLow));

	initial begin
		clk_sys = 1'b0;
		forever #2.5 clk_sys = ~clk_sys;
	end

	always @(posedge clk_sys) cycleCnt <= cycleCnt + 1;

	// ****************************************
	// Tasks
	// ****************************************
	task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		samplesChecked++;
		if (seen !== exp) begin
			failCount++;
			$display("Error %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task inRange(input string what, input int v, input int lo, input int hi);
		check(what, {31'h0, (v >= lo && v <= hi)}, 32'h1);
	endtask

	task wbCycle(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
		int n;
		n = 0;
		@(posedge clk_sys);
		wbCyc <= 1'b1;
		wbStb <= 1'b1;
		wbWe <= w;
		wbAdr <= a;
		wbDatW <= d;
		do begin
			@(posedge clk_sys);
			n++;
		end while (wbAck !== 1'b1 && n < 50);
		check("bus ack", {31'h0, wbAck}, 32'h1);
		q = wbDatR;
		wbCyc <= 1'b0;
		wbStb <= 1'b0;
		wbWe <= 1'b0;
	endtask

	task wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] t;
		wbCycle(1'b1, a, d, t);
	endtask

	task rd(input logic [7:0] a, output logic [31:0] q);
		wbCycle(1'b0, a, 32'h0000_0000, q);
	endtask

	// Counts edges until a probed enable drops, then how long it stays low
	task measure(input int idx, output int g, output int wd);
		g = 0;
		wd = 0;
		while (probe[idx] !== 1'b0 && g < 3000) begin
			@(posedge clk_sys);
			g++;
		end
		while (probe[idx] === 1'b0 && wd < 3000) begin
			@(posedge clk_sys);
			wd++;
		end
	endtask

	task waitIdle;
		int n;
		n = 0;
		do begin
			rd(fbpp_pkg::STATUS_OFS, r);
			n++;
		end while (r[4] !== 1'b0 && n < 1500);
		check("idle", {31'h0, r[4]}, 32'h0);
	endtask

	task pulseIn(input int k);
		@(posedge clk_sys);
		case (k)
			0: rxBitValid <= 1'b1;
			1: slaveTelegramOk <= 1'b1;
			default: masterTelegramOk <= 1'b1;
		endcase
		@(posedge clk_sys);
		rxBitValid <= 1'b0;
		slaveTelegramOk <= 1'b0;
		masterTelegramOk <= 1'b0;
	endtask

	task runParam(input logic [3:0] v, input logic [3:0] ext, input logic [3:0] expS);
		int t0;
		returnVal <= ext;
		wr(fbpp_pkg::STATUS_OFS, 32'h0000_0040);
		wr(fbpp_pkg::PARAM_OFS, {28'h0, v});
		t0 = cycleCnt;
		repeat (2) @(posedge clk_sys);
		check("pin enables", {28'h0, pinOe}, {28'h0, bidirMode ? 4'h0 : ~v});
		measure(4, gap, width);
		inRange("strobe setup", gap, 20, 120);
		inRange("strobe width", width, 1000, 1200);
		check("after strobe", {28'h0, pinOe}, {28'h0, bidirMode ? 4'h0 : ~v});
		do begin
			rd(fbpp_pkg::STATUS_OFS, r);
		end while (r[6] !== 1'b1 && cycleCnt - t0 < 3000);
		inRange("sample time", cycleCnt - t0, 2200, 2710);
		check("sample", {28'h0, r[3:0]}, {28'h0, expS});
		check("pin enables", {28'h0, pinOe}, {28'h0, ~v});
		check("data port", {31'h0, dpEn}, 32'h1);
	endtask

	task end_sim;
		$display("Checks %0d mismatches %0d", samplesChecked, failCount);
		if (failCount == 0 && samplesChecked > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	initial begin
		repeat (60000) @(posedge clk_sys);
		failCount++;
		$display("Error watchdog expired");
		end_sim();
	end

	// ****************************************
	// Tests
	// ****************************************
	initial begin
		{rst_b, wbCyc, wbStb, wbWe, rxBitValid, rxBitData, powerFail} = '0;
		{slaveTelegramOk, masterTelegramOk, bidirMode} = '0;
		{wbAdr, wbSel, wbDatW, returnVal} = {8'h00, 4'hF, 32'h0000_0000, 4'hF};
		{failCount, samplesChecked} = '0;
		repeat (16) @(posedge clk_sys);
		rst_b <= 1'b1;
		@(posedge clk_sys);
		check("reset enables", {28'h0, pinOe}, 32'h0);
		measure(4, gap, width);
		inRange("reset setup", gap, 20, 120);
		inRange("reset width", width, 1000, 1200);
		rd(fbpp_pkg::PARAM_OFS, r);
		check("reset param", r, 32'h0000_000F);
		check("data port off", {31'h0, dpEn}, 32'h0);
		rd(8'h10, r);
		check("unmapped", r, 32'h0000_0000);
		waitIdle();
		$display("Test reset done");
		runParam(4'h5, 4'hC, 4'h4);
		bidirMode <= 1'b1;
		wr(fbpp_pkg::CTRL_OFS, 32'h0000_0004);
		runParam(4'h3, 4'hA, 4'hA);
		$display("Test param done");
		bidirMode <= 1'b0;
		wr(fbpp_pkg::CTRL_OFS, 32'h0000_0000);
		wr(fbpp_pkg::PARAM_OFS, 32'h0000_0000);
		repeat (50) @(posedge clk_sys);
		wr(fbpp_pkg::CMD_OFS, 32'h0000_0001);
		repeat (2) @(posedge clk_sys);
		check("clear enables", {28'h0, pinOe}, 32'h0);
		measure(4, gap, width);
		inRange("clear width", width, 1000, 1200);
		rd(fbpp_pkg::PARAM_OFS, r);
		check("clear param", r, 32'h0000_000F);
		check("clear data port", {31'h0, dpEn}, 32'h0);
		waitIdle();
		$display("Test clear done");
		wr(fbpp_pkg::CTRL_OFS, 32'h0000_0070);
		for (int i = 0; i < 3; i++) begin
			returnVal <= ctlExt[i];
			if (ctlPar[i] != 4'hF) wr(fbpp_pkg::PARAM_OFS, {28'h0, ctlPar[i]});
			repeat (10) @(posedge clk_sys);
			check("pin controls", {29'h0, wdogEn, filtAct, syncAct}, {29'h0, ctlExp[i]});
		end
		wr(fbpp_pkg::CTRL_OFS, 32'h0000_0078);
		repeat (5) @(posedge clk_sys);
		check("wdog forced", {31'h0, wdogEn}, 32'h1);
		waitIdle();
		$display("Test control pins done");
		wr(fbpp_pkg::CTRL_OFS, 32'h0000_0071);
		repeat (10) @(posedge clk_sys);
		check("no input use", {31'h0, filtAct}, 32'h0);
		check("master pins", {30'h0, pinOe[3], pinOe[1]}, 32'h1);
		powerFail <= 1'b1;
		repeat (5) @(posedge clk_sys);
		check("power fail", {31'h0, pinOe[1]}, 32'h0);
		rxBitData <= 1'b1;
		pulseIn(0);
		measure(0, gap, width);
		inRange("rx clock delay", gap, 0, 5);
		check("rx data", {31'h0, rxOut}, 32'h1);
		pulseIn(1);
		measure(2, gap, width);
		check("slave strobe", width, 200);
		wr(fbpp_pkg::CTRL_OFS, 32'h0000_0003);
		pulseIn(2);
		measure(3, gap, width);
		check("master strobe", width, 200);
		wr(fbpp_pkg::CTRL_OFS, 32'h0000_0002);
		for (int k = 0; k < 3; k++) pulseIn(k);
		repeat (5) @(posedge clk_sys);
		check("repeater pins", {28'h0, pinOe}, 32'h0);
		$display("Test support modes done");
		end_sim();
	end
endmodule
